// ---- core/glcd_listener.sv ----
// listener-only bus interface and command decoder with apb status
//
// Contract
// - acceptor handshake, listener, remote/local only; open-collector style outputs
// - full-sweep-by-voltage: 0V band low end, 10V band high end
// - delta-F-by-voltage: 0V is CW minus half width, 10V plus half
// - both CW codes take frequency from panel CW pointer, no voltage
// - marker-sweep-by-voltage: 0V start pointer, 10V stop pointer
// - three panel sweep codes let panel controls act as in local
// - band codes one to four select band; band zero returns to lever
// - local marker code enables panel markers; remote enables programmed marker
// - power-up comes in local control
// - remote only with remote-enable true and own listen address received
// - on entering remote: panel mode, band zero, local markers, voltage undefined
// - remote-enable false or lost connection returns to local
// - addressing accepted in local and remote alike
// - listener only; talker and controller commands ignored
// - data lines one to five compared with five active-low switches
// - default listen address is ampersand, octal 046
// - stays addressed until unlisten or clear; code also unaddresses on link loss
// - unlisten byte under attention unaddresses
// - interface clear unaddresses regardless of handshake
// - voltage string V digits E; dot ignored; last four digits kept
// - colon counts as digit ten
// - settings persist; code order within message irrelevant
// - remote marker disables panel markers; local marker restores them
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "glcd_regs.svh"
module glcd_listener
  import glcd_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_dio_n,
  input  wire logic        i_dav_n,
  input  wire logic        i_atn_n,
  input  wire logic        i_ifc_n,
  input  wire logic        i_ren_n,
  input  wire logic        i_link_ok,
  input  wire logic [4:0]  i_address_switch_bank_n,
  input  wire logic [3:0]  i_panel_mode,
  output logic             o_nrfd_oe,
  output logic             o_ndac_oe,
  output logic             o_remote,
  output logic             o_listen,
  output logic [3:0]       o_mode,
  output logic [2:0]       o_band,
  output logic             o_panel_markers,
  output logic             o_prog_marker,
  output logic [15:0]      o_volt_mv,
  output logic             o_volt_valid,
  output logic             o_use_voltage,
  output logic             o_panel_sweep,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr
);
  localparam logic [4:0] ACCEPT_CYC = `GLCD_ACCEPT_CYC;

  glcd_hs_e    hs_ff;
  glcd_parse_e parse_ff;
  logic [4:0]  hold_ff;
  logic        listen_ff;
  logic        remote_ff;
  logic [3:0]  mode_ff;
  logic [2:0]  band_ff;
  logic        rmark_ff;
  logic [15:0] volt_ff;
  logic        volt_valid_ff;
  logic        en_ff;
  logic [4:0]  addr_ff;
  logic        addr_ovr_ff;
  logic [31:0] prdata_ff;
  logic        strap_done_ff;
  logic [6:0]  byte_w;
  logic        atn_w;
  logic        take_w;
  logic        my_listen_w;
  logic        unlisten_w;
  logic        data_w;
  logic        is_digit_w;
  logic [3:0]  digit_w;
  logic [15:0] digits_w;
  logic [4:0]  my_addr_w;
  logic        ifc_w;

  // bus lines are low-true; seven data bits form the character
  assign byte_w = ~i_dio_n[6:0];
  assign atn_w  = ~i_atn_n;
  assign ifc_w  = ~i_ifc_n;
  assign take_w = (hs_ff == GLCD_H_WAIT) && (hold_ff == 5'h00) && en_ff;

  assign my_addr_w  = addr_ovr_ff ? addr_ff : ~i_address_switch_bank_n;
  assign my_listen_w = (byte_w[6:5] == `GLCD_LISTEN_GROUP) && (byte_w[4:0] == my_addr_w);
  assign unlisten_w  = (byte_w == `GLCD_UNLISTEN);
  assign data_w      = take_w && !atn_w && listen_ff;

  assign is_digit_w = ((byte_w >= `GLCD_CH_0) && (byte_w <= `GLCD_CH_9))
                      || (byte_w == `GLCD_CH_COLON);
  assign digit_w    = byte_w[3:0];

  // acceptor handshake: hold not-ready low while busy, release data-accepted
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hs_ff   <= GLCD_H_READY;
      hold_ff <= 5'h00;
    end else begin
      unique case (hs_ff)
        GLCD_H_READY: begin
          if (!i_dav_n && en_ff) begin
            hs_ff   <= GLCD_H_WAIT;
            hold_ff <= ACCEPT_CYC - 5'h01;
          end
        end
        GLCD_H_WAIT: begin
          if (hold_ff != 5'h00) begin
            hold_ff <= hold_ff - 5'h01;
          end else begin
            hs_ff <= GLCD_H_DONE;
          end
        end
        GLCD_H_DONE: begin
          if (i_dav_n) begin
            hs_ff <= GLCD_H_READY;
          end
        end
        default: hs_ff <= GLCD_H_READY;
      endcase
    end
  end

  // pull lines (oe high pulls low): nrfd while byte in progress, ndac until accepted
  assign o_nrfd_oe = en_ff && (hs_ff != GLCD_H_READY);
  assign o_ndac_oe = en_ff && (hs_ff != GLCD_H_DONE);

  // startup flag, high from the first clock after reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
    end
  end

  // listen state held until unlisten, clear or link loss
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      listen_ff <= 1'b0;
    end else if (ifc_w || !i_link_ok) begin
      listen_ff <= 1'b0;
    end else if (take_w && atn_w) begin
      // addressing works in either control state
      if (my_listen_w) begin
        listen_ff <= 1'b1;
      end else if (unlisten_w) begin
        listen_ff <= 1'b0;
      end
    end
  end

  // reset to local; enter remote on own address with ren
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      remote_ff <= 1'b0;
    end else if (i_ren_n || !i_link_ok) begin
      remote_ff <= 1'b0;
    end else if (take_w && atn_w && my_listen_w) begin
      remote_ff <= 1'b1;
    end
  end

  glcd_digit_shift u_digits (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clear  (data_w && (byte_w == `GLCD_CH_V)),
    .i_push   (data_w && (parse_ff == GLCD_P_VOLT) && is_digit_w),
    .i_digit  (digit_w),
    .o_digits (digits_w)
  );

  // command parser: each letter starts its own code, any order
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      parse_ff <= GLCD_P_IDLE;
    end else if (!remote_ff || ifc_w) begin
      parse_ff <= GLCD_P_IDLE;
    end else if (data_w) begin
      if (byte_w == `GLCD_CH_M) begin
        parse_ff <= GLCD_P_MODE;
      end else if (byte_w == `GLCD_CH_B) begin
        parse_ff <= GLCD_P_BAND;
      end else if (byte_w == `GLCD_CH_V) begin
        parse_ff <= GLCD_P_VOLT;
      end else if ((parse_ff == GLCD_P_VOLT) && (is_digit_w || byte_w == `GLCD_CH_DOT)) begin
        parse_ff <= GLCD_P_VOLT;
      end else begin
        parse_ff <= GLCD_P_IDLE;
      end
    end
  end

  // decoded settings; defaults loaded on entry to remote
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_ff       <= 4'(GLCD_MODE_PANEL_FS);
      band_ff       <= 3'h0;
      rmark_ff      <= 1'b0;
      volt_ff       <= 16'h0000;
      volt_valid_ff <= 1'b0;
    end else if (!remote_ff) begin
      mode_ff       <= i_panel_mode;
      band_ff       <= 3'h0;
      rmark_ff      <= 1'b0;
      volt_valid_ff <= 1'b0;
    end else if (data_w) begin
      // unmatched characters fall through with no change
      if ((parse_ff == GLCD_P_MODE) && (byte_w >= 7'h31) && (byte_w <= 7'h38)) begin
        mode_ff <= byte_w[3:0];
      end
      if ((parse_ff == GLCD_P_BAND) && (byte_w >= `GLCD_CH_0) && (byte_w <= 7'h34)) begin
        band_ff <= byte_w[2:0];
      end
      // marker ownership swap; L and R codes
      if (byte_w == `GLCD_CH_R) begin
        rmark_ff <= 1'b1;
      end else if (byte_w == `GLCD_CH_L) begin
        rmark_ff <= 1'b0;
      end
      // voltage takes effect only at end character
      if ((parse_ff == GLCD_P_VOLT) && (byte_w == `GLCD_CH_E)) begin
        volt_ff       <= digits_w;
        volt_valid_ff <= 1'b1;
      end
    end
  end

  // voltage modes steer the analog path from the programmed value
  assign o_use_voltage = remote_ff && ((mode_ff == 4'(GLCD_MODE_FULL_V))
                         || (mode_ff == 4'(GLCD_MODE_DF_V)) || (mode_ff == 4'(GLCD_MODE_MK_V)));
  // local control and the three panel modes leave frequency to the panel
  assign o_panel_sweep = !remote_ff || (mode_ff == 4'(GLCD_MODE_PANEL_FS))
                         || (mode_ff == 4'(GLCD_MODE_PANEL_DF))
                         || (mode_ff == 4'(GLCD_MODE_PANEL_MK));
  assign o_remote        = remote_ff;
  assign o_listen        = listen_ff;
  assign o_mode          = mode_ff;
  assign o_band          = band_ff;
  assign o_panel_markers = !rmark_ff;
  assign o_prog_marker   = rmark_ff;
  assign o_volt_mv       = volt_ff;
  assign o_volt_valid    = volt_valid_ff;

  // apb: one wait-free access phase, unmapped reads zero with error
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !((i_paddr == `GLCD_APB_CTRL)
                     || (i_paddr == `GLCD_APB_STAT) || (i_paddr == `GLCD_APB_VOLT)
                     || (i_paddr == `GLCD_APB_SET));
  assign o_prdata  = prdata_ff;

  // control register: enable, default address at reset, override
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_ff       <= 1'b1;
      addr_ff     <= `GLCD_ADDR_DEFAULT;
      addr_ovr_ff <= 1'b0;
    end else if (i_psel && i_penable && i_pwrite && (i_paddr == `GLCD_APB_CTRL)) begin
      en_ff       <= i_pwdata[0];
      addr_ovr_ff <= i_pwdata[1];
      addr_ff     <= i_pwdata[12:8];
    end
  end

  // read data captured in setup so it stands in the access phase
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      unique case (i_paddr)
        `GLCD_APB_CTRL: prdata_ff <= {19'h0, addr_ff, 6'h0, addr_ovr_ff, en_ff};
        `GLCD_APB_STAT: prdata_ff <= {24'h0, strap_done_ff, volt_valid_ff, hs_ff,
                                      parse_ff, remote_ff, listen_ff};
        `GLCD_APB_VOLT: prdata_ff <= {16'h0, volt_ff};
        `GLCD_APB_SET:  prdata_ff <= {24'h0, rmark_ff, band_ff, mode_ff};
        default:        prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  property p_ifc_unlisten;
    @(posedge i_clk) disable iff (!i_resetn)
    ifc_w |=> !listen_ff;
  endproperty
  a_ifc_unlisten: assert property (p_ifc_unlisten) else $error("ifc left listener addressed");

  property p_ren_local;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ren_n |=> !remote_ff;
  endproperty
  a_ren_local: assert property (p_ren_local) else $error("remote held without ren");

  property p_remote_cause;
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(remote_ff) |-> $past(take_w && atn_w && my_listen_w && !i_ren_n);
  endproperty
  a_remote_cause: assert property (p_remote_cause) else $error("remote without address");

  property p_unlisten;
    @(posedge i_clk) disable iff (!i_resetn)
    (take_w && atn_w && unlisten_w && !my_listen_w) |=> !listen_ff;
  endproperty
  a_unlisten: assert property (p_unlisten) else $error("unlisten ignored");

  property p_volt_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    (remote_ff && $past(remote_ff) && !$past(data_w && byte_w == `GLCD_CH_E))
      |-> (volt_ff == $past(volt_ff));
  endproperty
  a_volt_hold: assert property (p_volt_hold) else $error("voltage changed mid string");

  property p_marker_excl;
    @(posedge i_clk) disable iff (!i_resetn)
    (remote_ff && data_w && (byte_w == `GLCD_CH_R)) |=> (o_prog_marker && !o_panel_markers);
  endproperty
  a_marker_excl: assert property (p_marker_excl) else $error("marker sources overlap");

  property p_local_defaults;
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(remote_ff) |-> (band_ff == 3'h0) && !rmark_ff && !volt_valid_ff
      && (mode_ff == $past(i_panel_mode));
  endproperty
  a_local_defaults: assert property (p_local_defaults) else $error("bad remote defaults");

  property p_accept_time;
    @(posedge i_clk) disable iff (!i_resetn)
    (hs_ff == GLCD_H_READY && !i_dav_n && en_ff) |=> (hs_ff == GLCD_H_WAIT) [*4] ##1 take_w;
  endproperty
  a_accept_time: assert property (p_accept_time) else $error("accept timing off");

  property p_listen_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    (listen_ff && !ifc_w && i_link_ok && !(take_w && atn_w)) |=> listen_ff;
  endproperty
  a_listen_hold: assert property (p_listen_hold) else $error("listener dropped");
endmodule // glcd_listener

// ---- core/glcd_regs.svh ----
// constants for the bus listener and command decoder
`ifndef GLCD_REGS_SVH
`define GLCD_REGS_SVH
`define GLCD_ADDR_DEFAULT   5'h06
`define GLCD_LISTEN_GROUP   2'h1
`define GLCD_UNLISTEN       7'h3F
`define GLCD_CH_M           7'h4D
`define GLCD_CH_B           7'h42
`define GLCD_CH_V           7'h56
`define GLCD_CH_E           7'h45
`define GLCD_CH_L           7'h4C
`define GLCD_CH_R           7'h52
`define GLCD_CH_DOT         7'h2E
`define GLCD_CH_0           7'h30
`define GLCD_CH_9           7'h39
`define GLCD_CH_COLON       7'h3A
`define GLCD_ACCEPT_NS      50
`define GLCD_CLK_NS         10
`define GLCD_ACCEPT_CYC     5'h05
`define GLCD_APB_CTRL       12'h000
`define GLCD_APB_STAT       12'h004
`define GLCD_APB_VOLT       12'h008
`define GLCD_APB_SET        12'h00C
`endif

// ---- core/glcd_pkg.sv ----
// types for the bus listener and command decoder
package glcd_pkg;
  typedef enum logic [3:0] {
    GLCD_MODE_FULL_V   = 4'h1,
    GLCD_MODE_DF_V     = 4'h2,
    GLCD_MODE_CW_A     = 4'h3,
    GLCD_MODE_MK_V     = 4'h4,
    GLCD_MODE_PANEL_FS = 4'h5,
    GLCD_MODE_PANEL_DF = 4'h6,
    GLCD_MODE_CW_B     = 4'h7,
    GLCD_MODE_PANEL_MK = 4'h8
  } glcd_mode_e;
  typedef enum logic [1:0] {
    GLCD_P_IDLE = 2'h0,
    GLCD_P_MODE = 2'h1,
    GLCD_P_BAND = 2'h2,
    GLCD_P_VOLT = 2'h3
  } glcd_parse_e;
  typedef enum logic [1:0] {
    GLCD_H_READY = 2'h0,
    GLCD_H_WAIT  = 2'h1,
    GLCD_H_DONE  = 2'h2
  } glcd_hs_e;
endpackage

// ---- core/glcd_digit_shift.sv ----
// four-digit millivolt shift register for the voltage string
`timescale 1ns/100ps
module glcd_digit_shift
  import glcd_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_clear,
  input  wire logic        i_push,
  input  wire logic [3:0]  i_digit,
  output logic      [15:0] o_digits
);
  logic [15:0] digits_ff;

  // newest digit enters low nibble, oldest falls off the top
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      digits_ff <= 16'h0000;
    end else if (i_clear) begin
      digits_ff <= 16'h0000;
    end else if (i_push) begin
      digits_ff <= {digits_ff[11:0], i_digit};
    end
  end

  assign o_digits = digits_ff;
endmodule // glcd_digit_shift

// ---- tb/glcd_ctrl_model.sv ----
// behavioural bus controller that talks to the listener
`timescale 1ns/100ps
module glcd_ctrl_model (
  input  wire logic       i_clk,
  input  wire logic       i_nrfd_oe,
  input  wire logic       i_ndac_oe,
  output logic      [7:0] o_dio_n,
  output logic            o_dav_n,
  output logic            o_atn_n,
  output logic            o_ifc_n,
  output logic            o_ren_n
);
  logic hang;  // set when the listener never answers
  int   slow;  // extra idle cycles before each byte

  // released lines float to the pull-up level
  initial begin
    o_dio_n = 8'hFF;
    o_dav_n = 1'b1;
    o_atn_n = 1'b1;
    o_ifc_n = 1'b1;
    o_ren_n = 1'b1;
    hang    = 1'b0;
    slow    = 0;
  end

  // bounded wait on one handshake enable
  task automatic hold_until(input logic use_ndac, input logic lvl);
    int n;
    n = 0;
    while (((use_ndac ? i_ndac_oe : i_nrfd_oe) !== lvl) && n < 500) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 500) hang = 1'b1;
  endtask

  // one byte: data first, then strobe, held until accepted
  task automatic send(input logic [7:0] b);
    hold_until(1'b0, 1'b0);
    repeat (slow) @(posedge i_clk);
    o_dio_n <= ~b;
    @(posedge i_clk);
    o_dav_n <= 1'b0;
    hold_until(1'b1, 1'b0);
    o_dav_n <= 1'b1;
    o_dio_n <= 8'hFF;
    hold_until(1'b1, 1'b1);
  endtask

  task automatic cmd(input logic [7:0] b);
    @(posedge i_clk);
    o_atn_n <= 1'b0;
    @(posedge i_clk);
    send(b);
    o_atn_n <= 1'b1;
  endtask

  // data string, one character per handshake
  task automatic text(input string s);
    foreach (s[i]) send(8'(s[i]));
  endtask

  // remote enable held as a level
  task automatic ren(input logic on);
    @(posedge i_clk);
    o_ren_n <= ~on;
  endtask

  // interface clear pulse
  task automatic ifc();
    @(posedge i_clk);
    o_ifc_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_ifc_n <= 1'b1;
  endtask
endmodule // glcd_ctrl_model

// ---- tb/glcd_listener_tb.sv ----
// self-checking bench for the listener and command decoder
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
module glcd_listener_tb;
  import glcd_pkg::*;
  logic        clk, resetn, link_ok, psel, pen, pwrite, pready, pslverr;
  logic [4:0]  sw_n;
  logic [3:0]  pmode, mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  dio_n;
  logic        dav_n, atn_n, ifc_n, ren_n, nrfd_oe, ndac_oe, remote, listen, pmk, prog;
  logic        vvalid, use_v, psweep, err;
  logic [2:0]  band;
  logic [15:0] volt;
  int          errors, checks;

  glcd_ctrl_model u_ctl (.i_clk(clk), .i_nrfd_oe(nrfd_oe), .i_ndac_oe(ndac_oe),
    .o_dio_n(dio_n), .o_dav_n(dav_n), .o_atn_n(atn_n), .o_ifc_n(ifc_n), .o_ren_n(ren_n));
  glcd_listener u_dut (.i_clk(clk), .i_resetn(resetn), .i_dio_n(dio_n), .i_dav_n(dav_n),
    .i_atn_n(atn_n), .i_ifc_n(ifc_n), .i_ren_n(ren_n), .i_link_ok(link_ok),
    .i_address_switch_bank_n(sw_n), .i_panel_mode(pmode), .o_nrfd_oe(nrfd_oe),
    .o_ndac_oe(ndac_oe), .o_remote(remote), .o_listen(listen), .o_mode(mode),
    .o_band(band), .o_panel_markers(pmk), .o_prog_marker(prog), .o_volt_mv(volt),
    .o_volt_valid(vvalid), .o_use_voltage(use_v), .o_panel_sweep(psweep), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));

  // verdict and end of run
  task results;
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata; err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    if (n >= 50) begin errors++; results; end
  endtask

  // let registered outputs land before looking
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // clock and hang guards
  always #5 clk = ~clk;
  always @(posedge clk) if (u_ctl.hang === 1'b1) begin errors++; results; end
  initial begin repeat (100000) @(posedge clk); errors++; results; end

  initial begin
    clk = 0; resetn = 0; link_ok = 1; sw_n = 5'b11001; pmode = 4'h6;
    psel = 0; pen = 0; pwrite = 0; paddr = 12'h000; pwdata = 32'h0; errors = 0; checks = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    settle();
    `CHK({remote, listen, nrfd_oe, ndac_oe}, 4'b0001);
    `CHK({mode, psweep}, 5'b01101);
    apb(1'b0, 12'h000, 32'h0); `CHK(rd, 32'h0000_0601);
    apb(1'b0, 12'h010, 32'h0); `CHK({err, rd}, 33'h1_0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0601); apb(1'b0, 12'h000, 32'h0); `CHK(rd, 32'h0000_0601);
    u_ctl.cmd(8'h26); settle(); `CHK({listen, remote}, 2'b10);
    u_ctl.ren(1'b1); u_ctl.cmd(8'h26); settle(); `CHK(remote, 1'b1);
    `CHK({mode, band, pmk, vvalid}, 9'b0110_000_1_0);
    apb(1'b0, 12'h004, 32'h0); `CHK(rd[1:0], 2'b11);
    u_ctl.text("M1B3V5.500E"); settle();
    `CHK({mode, band, volt, vvalid, use_v}, 25'h02D_5403);
    u_ctl.text("V12"); settle(); `CHK(volt, 16'h5500);
    u_ctl.text("3456E"); settle(); `CHK(volt, 16'h3456);
    u_ctl.text("V:000E"); settle(); `CHK(volt, 16'hA000);
    u_ctl.text("V10E"); settle(); `CHK(volt, 16'h0010);
    for (int m = 1; m <= 8; m++) begin
      u_ctl.send(8'h4D); u_ctl.send(8'h30 + 8'(m)); settle();
      `CHK(mode, 4'(m));
      `CHK(use_v, 1'(m == 1 || m == 2 || m == 4));
      `CHK(psweep, 1'(m == 5 || m == 6 || m == 8));
    end
    for (int b = 4; b >= 0; b--) begin
      u_ctl.send(8'h42); u_ctl.send(8'h30 + 8'(b)); settle(); `CHK(band, 3'(b));
    end
    u_ctl.text("R"); settle(); `CHK({prog, pmk}, 2'b10);
    u_ctl.text("L"); settle(); `CHK({prog, pmk}, 2'b01);
    u_ctl.text("B2M4"); settle(); `CHK({band, mode}, 7'b010_0100);
    u_ctl.text("Z"); settle(); `CHK({band, mode, volt}, 23'h24_0010);
    u_ctl.cmd(8'h46); settle(); `CHK(listen, 1'b1);
    u_ctl.cmd(8'h3F); settle(); `CHK(listen, 1'b0);
    u_ctl.text("M5"); settle(); `CHK({mode, remote}, 5'b0100_1);
    u_ctl.cmd(8'h26); u_ctl.ifc(); settle(); `CHK(listen, 1'b0);
    u_ctl.ren(1'b0); settle(); `CHK(remote, 1'b0);
    u_ctl.ren(1'b1); u_ctl.cmd(8'h26); settle(); `CHK(remote, 1'b1);
    @(posedge clk); link_ok <= 1'b0; settle(); `CHK({remote, listen}, 2'b00);
    @(posedge clk); link_ok <= 1'b1; u_ctl.slow = 3; sw_n <= ~5'h0A; pmode <= 4'h8;
    u_ctl.cmd(8'h26); settle(); `CHK({listen, mode}, 5'b0_1000);
    u_ctl.cmd(8'h2A); settle(); `CHK({listen, nrfd_oe, ndac_oe}, 3'b101);
    `CHK({remote, mode, psweep}, 6'b1_1000_1);
    u_ctl.cmd(8'h3F); apb(1'b1, 12'h000, 32'h0000_1203);
    u_ctl.cmd(8'h2A); settle(); `CHK(listen, 1'b0);
    u_ctl.cmd(8'h32); settle(); `CHK(listen, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_1202); settle(); `CHK({nrfd_oe, ndac_oe}, 2'b00);
    apb(1'b0, 12'h004, 32'h0); `CHK({rd[7], rd[1:0]}, 3'b111);
    results;
  end
endmodule // glcd_listener_tb
